//--- verilog/bchr_regs.sv
// bchr_regs: configuration header registers 0Ch to 1Ch of a pci-to-pci
// bridge, with secondary status flags, an interrupt mask and a control word.
// assumes a classic wishbone master on clk_i and event pulses from the
// bridge core on the same clock; the two bus pins arrive asynchronously.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none

module bchr_regs
  import bchr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // bridge core status, same clock
  input wire logic pci_mode_i,
  input wire logic rd_data_parity_err_i,
  input wire logic write_data_phase_i,
  input wire logic split_perr_msg_i,
  input wire logic target_abort_signaled_i,
  input wire logic target_abort_received_i,
  input wire logic master_abort_received_i,
  input wire logic addr_parity_err_i,
  input wire logic data_parity_err_i,
  // secondary bus pins, asynchronous, active low
  input wire logic downstream_parity_error_pin_n_i,
  input wire logic downstream_serr_pin_n_i,
  // configuration toward the bridge core
  output logic [7:0] upstream_bus_number_o,
  output logic [7:0] downstream_bus_number_o,
  output logic [7:0] highest_bus_number_o,
  output logic [7:0] downstream_latency_timer_o,
  output logic [3:0] io_base_o,
  output logic [3:0] io_limit_o,
  output logic parity_error_enable_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte lane merge, used by every byte of the bus number word
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
    lane_merge = en ? new_v : old_v;
  endfunction

  // two-flop-agree filter on a three stage synchroniser
  function automatic logic pin_filter(input logic [SYNC_STAGES-1:0] chain,
                                      input logic cur);
    pin_filter = (chain[1] == chain[2]) ? chain[1] : cur;
  endfunction

  // word select on the dword part of the byte address; bits 1:0 never matter
  function automatic logic word_hit(input logic [7:0] adr,
                                    input logic [7:0] ofs);
    word_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] upstream_bus_number;
  logic [7:0] downstream_bus_number;
  logic [7:0] highest_bus_number;
  logic [7:0] downstream_latency_timer;
  logic [3:0] io_base;
  logic [3:0] io_limit;
  logic [7:0] flags;
  logic [7:0] irq_mask;
  logic parity_error_enable;
  logic [SYNC_STAGES-1:0] perr_sync;
  logic [SYNC_STAGES-1:0] serr_sync;
  logic perr_n_filt;
  logic serr_n_filt;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // one wait state: data is latched as ack rises, a write lands on the
  // edge where the master samples ack high
  wire req_new = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire sel_hdr = word_hit(wb_adr_i, OFS_HDR);
  wire sel_rsvd = word_hit(wb_adr_i, OFS_RSVD_A) |
                  word_hit(wb_adr_i, OFS_RSVD_B);
  wire sel_bus = word_hit(wb_adr_i, OFS_BUS);
  wire sel_io = word_hit(wb_adr_i, OFS_IO_STAT);
  wire sel_mask = word_hit(wb_adr_i, OFS_IRQ_MASK);
  wire sel_ctrl = word_hit(wb_adr_i, OFS_CTRL);
  wire wr_bus = wr_fire & sel_bus;
  wire wr_io = wr_fire & sel_io;
  wire wr_mask = wr_fire & sel_mask;
  wire wr_ctrl = wr_fire & sel_ctrl;

  // ---------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------
  wire [31:0] word_hdr = {8'h00, HDR_MULTI_FN, HDR_LAYOUT, PRI_LAT_VALUE, 8'h00};
  wire [31:0] word_bus = {downstream_latency_timer, highest_bus_number,
                          downstream_bus_number, upstream_bus_number};
  wire [7:0] status_lo = {pci_mode_i, 1'b0, CAP_66MHZ, 5'h00};
  wire [7:0] status_hi = (flags & FLAG_STICKY) |
                         {5'h00, DEVSEL_TIMING, 1'b0};
  wire [31:0] word_io = {status_hi, status_lo,
                         io_limit, 2'h0, IO_ADDR_CAP,
                         io_base, 2'h0, IO_ADDR_CAP};
  wire [31:0] word_mask = {irq_mask, 24'h00_0000};
  wire [31:0] word_ctrl = {31'h0000_0000, parity_error_enable};

  // ---------------------------------------------------------------
  // read multiplexer
  // ---------------------------------------------------------------
  // reserved and unmapped words read zero and ignore writes; the reserved
  // pair is decoded on its own so it can never alias a live register
  logic [31:0] rd_word;

  always_comb begin
    if (sel_hdr) begin
      rd_word = word_hdr;
    end else if (sel_rsvd) begin
      rd_word = 32'h0000_0000;
    end else if (sel_bus) begin
      rd_word = word_bus;
    end else if (sel_io) begin
      rd_word = word_io;
    end else if (sel_mask) begin
      rd_word = word_mask;
    end else if (sel_ctrl) begin
      rd_word = word_ctrl;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // wishbone handshake
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req_new;
      if (req_new) begin
        wb_dat_o <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // bus numbers and latency timer
  // ---------------------------------------------------------------
  // the non-pci reset value keeps the timer sane for the other bus mode
  wire [7:0] sec_lat_rst = pci_mode_i ? SEC_LAT_RST_PCI : SEC_LAT_RST_OTHER;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upstream_bus_number <= BUS_NUM_RST;
    end else if (wr_bus) begin
      upstream_bus_number <= lane_merge(upstream_bus_number, wb_dat_i[7:0], wb_sel_i[0]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      downstream_bus_number <= BUS_NUM_RST;
    end else if (wr_bus) begin
      downstream_bus_number <= lane_merge(downstream_bus_number, wb_dat_i[15:8],
                                          wb_sel_i[1]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      highest_bus_number <= BUS_NUM_RST;
    end else if (wr_bus) begin
      highest_bus_number <= lane_merge(highest_bus_number, wb_dat_i[23:16], wb_sel_i[2]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      downstream_latency_timer <= sec_lat_rst;
    end else if (wr_bus) begin
      downstream_latency_timer <= lane_merge(downstream_latency_timer, wb_dat_i[31:24],
                                             wb_sel_i[3]);
    end
  end

  // ---------------------------------------------------------------
  // io window
  // ---------------------------------------------------------------
  // only the upper nibbles store; the low nibbles are fixed fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_base <= IO_NIBBLE_RST;
    end else if (wr_io & wb_sel_i[0]) begin
      io_base <= wb_dat_i[7:4];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_limit <= IO_NIBBLE_RST;
    end else if (wr_io & wb_sel_i[1]) begin
      io_limit <= wb_dat_i[15:12];
    end
  end

  // ---------------------------------------------------------------
  // control and mask
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      parity_error_enable <= PERR_EN_RST;
    end else if (wr_ctrl & wb_sel_i[0]) begin
      parity_error_enable <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= MASK_RST;
    end else if (wr_mask & wb_sel_i[3]) begin
      irq_mask <= wb_dat_i[31:24] & FLAG_STICKY;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // idle level of both pins is high; filtered level moves only once
  // the second and third stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      perr_sync <= '1;
      perr_n_filt <= 1'b1;
    end else begin
      perr_sync <= {perr_sync[SYNC_STAGES-2:0], downstream_parity_error_pin_n_i};
      perr_n_filt <= pin_filter(perr_sync, perr_n_filt);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serr_sync <= '1;
      serr_n_filt <= 1'b1;
    end else begin
      serr_sync <= {serr_sync[SYNC_STAGES-2:0], downstream_serr_pin_n_i};
      serr_n_filt <= pin_filter(serr_sync, serr_n_filt);
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  wire mdpe_event = parity_error_enable &
                    (rd_data_parity_err_i |
                     (write_data_phase_i & ~perr_n_filt) |
                     split_perr_msg_i);
  wire [7:0] flag_set;
  assign flag_set[FLG_MDPE] = mdpe_event;
  assign flag_set[2:1] = 2'h0;
  assign flag_set[FLG_STA] = target_abort_signaled_i;
  assign flag_set[FLG_RTA] = target_abort_received_i;
  assign flag_set[FLG_RMA] = master_abort_received_i;
  assign flag_set[FLG_RSE] = ~serr_n_filt;
  assign flag_set[FLG_DPE] = addr_parity_err_i | data_parity_err_i;
  // a write of one clears; a set in the same cycle wins
  wire [7:0] flag_clr = (wr_io & wb_sel_i[3]) ? wb_dat_i[31:24] : 8'h00;
  wire [7:0] next_flags = ((flags & ~flag_clr) | flag_set) & FLAG_STICKY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags <= FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign irq_o = |(flags & irq_mask);
  assign upstream_bus_number_o = upstream_bus_number;
  assign downstream_bus_number_o = downstream_bus_number;
  assign highest_bus_number_o = highest_bus_number;
  assign downstream_latency_timer_o = downstream_latency_timer;
  assign io_base_o = io_base;
  assign io_limit_o = io_limit;
  assign parity_error_enable_o = parity_error_enable;

endmodule // bchr_regs

`default_nettype wire

//--- shared/bchr_pkg.sv
// bchr_pkg: offsets, field positions, reset values and constants of the
// bridge configuration header register bank.
// assumes a wishbone byte address of 8 bits; all offsets are word aligned.
package bchr_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_HDR = 8'h0C;
  localparam logic [7:0] OFS_RSVD_A = 8'h10;
  localparam logic [7:0] OFS_RSVD_B = 8'h14;
  localparam logic [7:0] OFS_BUS = 8'h18;
  localparam logic [7:0] OFS_IO_STAT = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
  localparam logic [7:0] OFS_CTRL = 8'h44;

  // ---------------------------------------------------------------
  // fixed field values
  // ---------------------------------------------------------------
  localparam logic [7:0] PRI_LAT_VALUE = 8'h00;
  localparam logic [6:0] HDR_LAYOUT = 7'h01;
  localparam logic HDR_MULTI_FN = 1'b0;
  localparam logic [1:0] IO_ADDR_CAP = 2'h1;
  localparam logic [1:0] DEVSEL_TIMING = 2'h1;
  localparam logic CAP_66MHZ = 1'b1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_NUM_RST = 8'h00;
  localparam logic [7:0] SEC_LAT_RST_PCI = 8'h00;
  localparam logic [7:0] SEC_LAT_RST_OTHER = 8'h40;
  localparam logic [3:0] IO_NIBBLE_RST = 4'h0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic PERR_EN_RST = 1'b0;

  // ---------------------------------------------------------------
  // secondary status flag positions within byte 3 of offset 1Ch
  // ---------------------------------------------------------------
  localparam int FLG_MDPE = 0;
  localparam int FLG_STA = 3;
  localparam int FLG_RTA = 4;
  localparam int FLG_RMA = 5;
  localparam int FLG_RSE = 6;
  localparam int FLG_DPE = 7;
  localparam logic [7:0] FLAG_STICKY = 8'hF9;

  // ---------------------------------------------------------------
  // pin input filter depth
  // ---------------------------------------------------------------
  localparam int SYNC_STAGES = 3;

endpackage : bchr_pkg

//--- dv/bchr_regs_chk.sv
// bchr_regs_chk: concurrent checks on the ports of the register bank.
// assumes one clock, synchronous reset and a master holding requests until ack.
`timescale 1ns/1ns
`default_nettype none

module bchr_regs_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic pci_mode_i,
  input wire logic rd_data_parity_err_i,
  input wire logic target_abort_signaled_i,
  input wire logic addr_parity_err_i,
  input wire logic data_parity_err_i,
  input wire logic [7:0] upstream_bus_number_o,
  input wire logic parity_error_enable_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_ack = wb_ack_o && !wb_we_i;
  wire rd_stat = rd_ack && wb_adr_i[7:2] == 6'h07;
  logic [7:0] last_lo;
  // write data is sampled one edge back, as the register takes it at the ack edge
  always_ff @(posedge clk_i) last_lo <= wb_dat_i[7:0];
  property p_hdr; rd_ack && wb_adr_i[7:2] == 6'h03 |-> wb_dat_o == 32'h0001_0000; endproperty
  a_hdr: assert property (p_hdr)
    else $error("header word read wrong");
  property p_rsvd; rd_ack && wb_adr_i[7:3] == 5'h02 |-> wb_dat_o == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word not zero");
  property p_stat; rd_stat |-> wb_dat_o[26:25] == 2'h1 && wb_dat_o[22:16] == 7'h20; endproperty
  a_stat: assert property (p_stat)
    else $error("fixed status bits wrong");
  property p_fbb; rd_stat |-> wb_dat_o[23] == $past(pci_mode_i); endproperty
  a_fbb: assert property (p_fbb)
    else $error("fast back to back bit wrong");
  property p_sta; rd_stat && $past(target_abort_signaled_i, 2) |-> wb_dat_o[27]; endproperty
  a_sta: assert property (p_sta)
    else $error("signalled abort flag missing");
  property p_dpe;
    rd_stat && ($past(addr_parity_err_i, 2) || $past(data_parity_err_i, 2)) |-> wb_dat_o[31];
  endproperty
  a_dpe: assert property (p_dpe)
    else $error("detected parity flag missing");
  property p_mdpe;
    rd_stat && $past(rd_data_parity_err_i, 2) && $past(parity_error_enable_o, 2)
      |-> wb_dat_o[24];
  endproperty
  a_mdpe: assert property (p_mdpe)
    else $error("master parity flag missing");
  property p_bus;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h18 && wb_sel_i[0] |=> upstream_bus_number_o == last_lo;
  endproperty
  a_bus: assert property (p_bus)
    else $error("bus number not written");
endmodule // bchr_regs_chk

bind bchr_regs bchr_regs_chk bchr_regs_chk_i (.clk_i, .rst_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .pci_mode_i, .rd_data_parity_err_i, .target_abort_signaled_i,
  .addr_parity_err_i, .data_parity_err_i, .upstream_bus_number_o, .parity_error_enable_o);
`default_nettype wire

//--- dv/bchr_core_model.sv
// bchr_core_model: bridge core events and secondary bus pins.
// assumes the pins are pulled up, so a released pin reads high.
`timescale 1ns/1ns
`default_nettype none

module bchr_core_model (
  input wire logic clk_i,
  output logic pci_mode_o,
  output logic [6:0] event_o,
  output logic write_phase_o,
  output logic parity_pin_n_o,
  output logic serr_pin_n_o
);
  // ----
  // far side
  // ----
  initial begin
    pci_mode_o = 1'b1;
    event_o = 7'h00;
    write_phase_o = 1'b0;
    parity_pin_n_o = 1'b1;
    serr_pin_n_o = 1'b1;
  end
  // pins are held long enough to pass the input filter
  // only what was raised is released, so back-to-back calls touch one signal
  // twice in a time step only when both use event_o or repeat a pin case
  task automatic fire(input int k);
    if (k < 7) begin
      event_o <= 7'h01 << k;
      @(posedge clk_i);
      event_o <= 7'h00;
    end else if (k == 7) begin
      write_phase_o <= 1'b1;
      parity_pin_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      write_phase_o <= 1'b0;
      parity_pin_n_o <= 1'b1;
    end else begin
      serr_pin_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
      serr_pin_n_o <= 1'b1;
    end
  endtask
  // mode is changed only while the bench holds reset
  task automatic set_mode(input logic m);
    pci_mode_o <= m;
  endtask
endmodule // bchr_core_model
`default_nettype wire

//--- dv/bchr_regs_tb.sv
// bchr_regs_tb: register accesses over classic wishbone with expected values.
// assumes one ack a request and flags set by the core model.
`timescale 1ns/1ns
`default_nettype none

module bchr_regs_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic wb_ack_o, irq_o, pci_mode_i, write_data_phase_i, parity_error_enable_o;
  logic downstream_parity_error_pin_n_i, downstream_serr_pin_n_i;
  logic [6:0] ev;
  logic [7:0] upstream_bus_number_o, downstream_bus_number_o, highest_bus_number_o;
  logic [7:0] downstream_latency_timer_o;
  logic [3:0] io_base_o, io_limit_o;
  int n_fail = 0, check_count = 0;
  int bitpos [9] = '{24, 24, 27, 28, 29, 31, 31, 24, 30};
  logic [31:0] stat0 = 32'h02A0_F1F1;
  always #25 clk_i = ~clk_i;

  bchr_core_model bchr_core_model_i (.clk_i, .pci_mode_o(pci_mode_i), .event_o(ev),
    .write_phase_o(write_data_phase_i), .parity_pin_n_o(downstream_parity_error_pin_n_i),
    .serr_pin_n_o(downstream_serr_pin_n_i));
  bchr_regs bchr_regs_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .pci_mode_i, .rd_data_parity_err_i(ev[0]),
    .write_data_phase_i, .split_perr_msg_i(ev[1]), .target_abort_signaled_i(ev[2]),
    .target_abort_received_i(ev[3]), .master_abort_received_i(ev[4]),
    .addr_parity_err_i(ev[5]), .data_parity_err_i(ev[6]), .downstream_parity_error_pin_n_i,
    .downstream_serr_pin_n_i, .upstream_bus_number_o, .downstream_bus_number_o,
    .highest_bus_number_o, .downstream_latency_timer_o, .io_base_o, .io_limit_o,
    .parity_error_enable_o);

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // ----
  // wishbone master: hold until ack, then release for one idle cycle
  // ----
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      summarize();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, s, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 4'hF, 32'h0000_0000, q);
    chk($sformatf("reg %h", a), q, e);
  endtask

  initial begin
    logic [31:0] f;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h18, 32'h0000_0000);
    rdc(8'h1C, 32'h02A0_0101);
    wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    wr(8'h14, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0001_0000);
    rdc(8'h14, 32'h0000_0000);
    rdc(8'h80, 32'h0000_0000);
    wr(8'h18, 4'hF, 32'hA5C3_3C5A);
    wr(8'h18, 4'h2, 32'h0000_7700);
    rdc(8'h18, 32'hA5C3_775A);
    chk("bus outputs", {downstream_latency_timer_o, highest_bus_number_o,
      downstream_bus_number_o, upstream_bus_number_o}, 32'hA5C3_775A);
    wr(8'h1C, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h1C, stat0);
    chk("io window", 32'({io_limit_o, io_base_o}), 32'h0000_00FF);
    wr(8'h44, 4'h1, 32'h0000_0001);
    rdc(8'h44, 32'h0000_0001);
    chk("parity enable", 32'(parity_error_enable_o), 32'h0000_0001);
    wr(8'h40, 4'h8, 32'hFF00_0000);
    rdc(8'h40, 32'hF900_0000);
    for (int k = 0; k < 9; k++) begin
      f = 32'h0000_0001 << bitpos[k];
      bchr_core_model_i.fire(k);
      rdc(8'h1C, stat0 | f);
      chk("irq set", 32'(irq_o), 32'h0000_0001);
      wr(8'h1C, 4'h8, ~f);
      rdc(8'h1C, stat0 | f);
      wr(8'h1C, 4'h8, f);
      rdc(8'h1C, stat0);
      chk("irq clear", 32'(irq_o), 32'h0000_0000);
    end
    // parity enable off: only the unconditional flag may set
    wr(8'h44, 4'h1, 32'h0000_0000);
    chk("parity disable", 32'(parity_error_enable_o), 32'h0000_0000);
    bchr_core_model_i.fire(0);
    bchr_core_model_i.fire(7);
    rdc(8'h1C, stat0);
    bchr_core_model_i.fire(6);
    rdc(8'h1C, stat0 | 32'h8000_0000);
    wr(8'h40, 4'h8, 32'h0000_0000);
    chk("irq masked", 32'(irq_o), 32'h0000_0000);
    bchr_core_model_i.set_mode(1'b0);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(8'h1C, 32'h0220_0101);
    rdc(8'h18, 32'h4000_0000);
    chk("latency output", 32'(downstream_latency_timer_o), 32'h0000_0040);
    summarize();
  end
endmodule // bchr_regs_tb
`default_nettype wire
